// ===== rtl/msch_sched.sv
`timescale 1ns/100ps
`include "msch_params.svh"
module msch_sched
#(
   parameter int CYC_PER_SEC = `MSCH_CLK_HZ,
   parameter int FAST_SEC = `MSCH_CAL_FAST_TIME_MIN * 60,
   parameter int SLOW_SEC = `MSCH_CAL_SLOW_TIME_MIN * 60,
   parameter int FAST_COUNT = `MSCH_FIRST_PHASE_TIME_MIN / `MSCH_CAL_FAST_TIME_MIN
)
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic restart_in,
   input wire logic auto_en_in,
   output logic due_out
);
   msch_pkg::msch_sched_t st_r;
   msch_pkg::msch_sched_t st_nxt;
   logic [11:0] period;

   // ----------------------------------------
   // interval timeline since reset or the last restart_in
   // ----------------------------------------
   // short interval until the first hour has passed, then the long one
   assign period = (st_r.fast_cnt < 3'(FAST_COUNT)) ? 12'(FAST_SEC) : 12'(SLOW_SEC);

   // timeline keeps running while disabled so re-enabling keeps the phase
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.due = 1'b0;
      if (restart_in)
      begin
         st_nxt = '0;
      end
      else if (st_r.pre == 26'(CYC_PER_SEC - 1))
      begin
         st_nxt.pre = '0;
         if (st_r.sec + 12'h001 >= period)
         begin
            st_nxt.sec = '0;
            st_nxt.due = auto_en_in;
            if (st_r.fast_cnt < 3'(FAST_COUNT))
            begin
               st_nxt.fast_cnt = st_r.fast_cnt + 3'h1;
            end
         end
         else
         begin
            st_nxt.sec = st_r.sec + 12'h001;
         end
      end
      else
      begin
         st_nxt.pre = st_r.pre + 26'h0000001;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_b_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign due_out = st_r.due;
endmodule // msch_sched

// ===== rtl/msch_top.sv
`timescale 1ns/100ps
`include "msch_params.svh"
module msch_top
#(
   parameter int CYC_PER_SEC = `MSCH_CLK_HZ,
   parameter int FAST_SEC = `MSCH_CAL_FAST_TIME_MIN * 60,
   parameter int SLOW_SEC = `MSCH_CAL_SLOW_TIME_MIN * 60,
   parameter logic [7:0] FW_RELEASE = 8'h10 // arbitrary release code
)
(
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire logic CMD_VALID_IN,
   input wire logic [3:0] CMD_CODE_IN,
   input wire logic [7:0] CMD_ARG_IN,
   input wire logic PARAM_OK_IN,
   input wire logic CHAN_ON_IN,
   input wire logic MEAS_LOW_IN,
   input wire logic MEAS_HIGH_IN,
   input wire logic REPLY_READY_IN,
   output logic CMD_READY_OUT,
   output logic REPLY_VALID_OUT,
   output msch_pkg::msch_reply_t REPLY_OUT,
   output logic [7:0] CTRL_WORD_OUT,
   output logic FACTORY_LOAD_OUT,
   output logic STORE_CFG_OUT,
   output logic CAL_START_OUT
);
   msch_pkg::msch_state_t st_r;
   msch_pkg::msch_state_t st_nxt;
   logic accept;
   logic sched_due;
   logic cal_due;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic msch_pkg::msch_reply_t mk_reply(input msch_pkg::msch_rpl_t kind, input logic [7:0] data);
      msch_pkg::msch_reply_t r;
      r.kind = kind;
      r.data = data;
      return r;
   endfunction

   // one command in flight; a pending banner also blocks new commands
   assign CMD_READY_OUT = !st_r.reply_valid && !st_r.banner_pend;
   assign accept = CMD_VALID_IN && CMD_READY_OUT;

   // ----------------------------------------
   // automatic calibration timing
   // ----------------------------------------
   msch_sched
   #(
      .CYC_PER_SEC(CYC_PER_SEC),
      .FAST_SEC(FAST_SEC),
      .SLOW_SEC(SLOW_SEC)
   )
   i_msch_sched
   (
      .clk_in(CLK_IN),
      .rst_b_in(RST_B_IN),
      .restart_in(st_r.sched_restart),
      .auto_en_in(!st_r.ctrl[`MSCH_CTRL_MANUAL_BIT]),
      .due_out(sched_due)
   );

   // gate again here: bit 0 may have been set since the timer fired
   assign cal_due = sched_due && !st_r.ctrl[`MSCH_CTRL_MANUAL_BIT];

   // ----------------------------------------
   // command interpreter
   // ----------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.factory = 1'b0;
      st_nxt.store = 1'b0;
      st_nxt.cal_start = cal_due;
      st_nxt.sched_restart = 1'b0;
      if (st_r.reply_valid && REPLY_READY_IN)
      begin
         st_nxt.reply_valid = 1'b0;
      end
      if (st_r.banner_pend && !st_r.reply_valid)
      begin
         // banner goes out right after any reset, well inside its deadline
         st_nxt.reply_valid = 1'b1;
         st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_BANNER, FW_RELEASE);
         st_nxt.banner_pend = 1'b0;
      end
      else if (accept)
      begin
         st_nxt.reply_valid = 1'b1;
         st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_OK, 8'h00);
         case (CMD_CODE_IN)
            msch_pkg::MSCH_CMD_RESTORE:
            begin
               // config side keeps the range on this strobe; then a full reset
               st_nxt.factory = 1'b1;
               st_nxt.reply_valid = 1'b0;
               st_nxt.banner_pend = 1'b1;
               st_nxt.ctrl = `MSCH_CTRL_RST;
               st_nxt.sched_restart = 1'b1;
               st_nxt.cal_start = 1'b0;
            end
            msch_pkg::MSCH_CMD_RESET:
            begin
               st_nxt.reply_valid = 1'b0;
               st_nxt.banner_pend = 1'b1;
               st_nxt.ctrl = `MSCH_CTRL_RST;
               st_nxt.sched_restart = 1'b1;
               st_nxt.cal_start = 1'b0;
            end
            msch_pkg::MSCH_CMD_STORE:
            begin
               st_nxt.store = 1'b1;
            end
            msch_pkg::MSCH_CMD_CAL_NOW:
            begin
               st_nxt.cal_start = 1'b1;
            end
            msch_pkg::MSCH_CMD_CTRL_WR:
            begin
               st_nxt.ctrl = CMD_ARG_IN;
               st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_CTRL, CMD_ARG_IN);
               // only the rising edge starts a cycle; host must clear it between
               if (CMD_ARG_IN[`MSCH_CTRL_START_BIT] && !st_r.ctrl[`MSCH_CTRL_START_BIT])
               begin
                  st_nxt.cal_start = 1'b1;
               end
            end
            msch_pkg::MSCH_CMD_CTRL_RD:
            begin
               st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_CTRL, st_r.ctrl);
            end
            msch_pkg::MSCH_CMD_CFG_WR:
            begin
               if (!PARAM_OK_IN)
               begin
                  st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_RANGE);
               end
            end
            msch_pkg::MSCH_CMD_MEAS_RD:
            begin
               // channel-off checked first, then the measurement limits
               if (!CHAN_ON_IN)
               begin
                  st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_CHAN_OFF);
               end
               else if (MEAS_LOW_IN)
               begin
                  st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_BELOW);
               end
               else if (MEAS_HIGH_IN)
               begin
                  st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_ABOVE);
               end
               else
               begin
                  st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_VALUE, CMD_ARG_IN);
               end
            end
            default:
            begin
               st_nxt.reply = mk_reply(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_UNKNOWN);
            end
         endcase
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge CLK_IN)
   begin
      if (!RST_B_IN)
      begin
         st_r <= '0;
         st_r.ctrl <= `MSCH_CTRL_RST;
         st_r.banner_pend <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign REPLY_VALID_OUT = st_r.reply_valid;
   assign REPLY_OUT = st_r.reply;
   assign CTRL_WORD_OUT = st_r.ctrl;
   assign FACTORY_LOAD_OUT = st_r.factory;
   assign STORE_CFG_OUT = st_r.store;
   assign CAL_START_OUT = st_r.cal_start;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);

   AST_RESTORE_SEQ: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_RESTORE |=>
      FACTORY_LOAD_OUT && !REPLY_VALID_OUT && CTRL_WORD_OUT == `MSCH_CTRL_RST ##1
      REPLY_VALID_OUT && REPLY_OUT.kind == msch_pkg::MSCH_RPL_BANNER)
      else $error("restore did not reload and send banner");
   AST_STORE_OK: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_STORE |=>
      STORE_CFG_OUT && REPLY_VALID_OUT && REPLY_OUT.kind == msch_pkg::MSCH_RPL_OK)
      else $error("store did not strobe or reply OK");
   AST_CAL_NOW: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_CAL_NOW |=>
      CAL_START_OUT && REPLY_OUT.kind == msch_pkg::MSCH_RPL_OK)
      else $error("calibrate-now did not start a cycle");
   // a reset or restore taken in the same cycle cancels the pending start
   AST_AUTO_CAL: assert property (sched_due && !CTRL_WORD_OUT[0] && !(accept
      && (CMD_CODE_IN == msch_pkg::MSCH_CMD_RESTORE || CMD_CODE_IN == msch_pkg::MSCH_CMD_RESET)) |=> CAL_START_OUT)
      else $error("automatic calibration not started");
   AST_MANUAL_ONLY: assert property (CTRL_WORD_OUT[0] && !accept |=> !CAL_START_OUT)
      else $error("calibration started without request in manual mode");
   AST_EDGE_START: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_CTRL_WR && CMD_ARG_IN[1]
      && !CTRL_WORD_OUT[1] |=> CAL_START_OUT)
      else $error("rising start bit did not start a cycle");
   AST_CTRL_WR: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_CTRL_WR |=>
      CTRL_WORD_OUT == $past(CMD_ARG_IN) && REPLY_OUT.data == $past(CMD_ARG_IN)
      && REPLY_OUT.kind == msch_pkg::MSCH_RPL_CTRL)
      else $error("control write not loaded or echoed");
   AST_CTRL_RD: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_CTRL_RD |=>
      REPLY_OUT.data == $past(CTRL_WORD_OUT) && REPLY_OUT.kind == msch_pkg::MSCH_RPL_CTRL)
      else $error("control read returned wrong value");
   AST_BANNER: assert property ($rose(RST_B_IN) |=> REPLY_VALID_OUT
      && REPLY_OUT.kind == msch_pkg::MSCH_RPL_BANNER && REPLY_OUT.data == FW_RELEASE)
      else $error("no banner after reset");
   AST_UNKNOWN: assert property (accept && CMD_CODE_IN > 4'h7 |=>
      REPLY_OUT.kind == msch_pkg::MSCH_RPL_ERR && REPLY_OUT.data == `MSCH_ERR_UNKNOWN && !FACTORY_LOAD_OUT
      && !STORE_CFG_OUT && (!CAL_START_OUT || $past(cal_due)) && CTRL_WORD_OUT == $past(CTRL_WORD_OUT))
      else $error("unknown command not rejected");
   AST_RANGE: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_CFG_WR && !PARAM_OK_IN |=>
      REPLY_OUT.data == `MSCH_ERR_RANGE)
      else $error("range error missing");
   AST_CHAN_OFF: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_MEAS_RD && !CHAN_ON_IN |=>
      REPLY_OUT.kind == msch_pkg::MSCH_RPL_ERR && REPLY_OUT.data == `MSCH_ERR_CHAN_OFF)
      else $error("channel-off error missing");
   AST_LIMITS: assert property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_MEAS_RD && CHAN_ON_IN
      && (MEAS_LOW_IN || MEAS_HIGH_IN) |=> REPLY_OUT.data == ($past(MEAS_LOW_IN) ? `MSCH_ERR_BELOW
      : `MSCH_ERR_ABOVE))
      else $error("limit error missing");

   CVR_BANNER: cover property (REPLY_VALID_OUT && REPLY_OUT.kind == msch_pkg::MSCH_RPL_BANNER && REPLY_READY_IN);
   CVR_AUTO: cover property (cal_due);
   CVR_EDGE: cover property (accept && CMD_CODE_IN == msch_pkg::MSCH_CMD_CTRL_WR ##1 CAL_START_OUT);
endmodule // msch_top

// ===== shared/msch_params.svh
`ifndef MSCH_PARAMS_SVH
`define MSCH_PARAMS_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define MSCH_CLK_HZ 40000000
`define MSCH_CAL_FAST_TIME_MIN 15
`define MSCH_CAL_SLOW_TIME_MIN 60
`define MSCH_FIRST_PHASE_TIME_MIN 60
`define MSCH_BANNER_MAX_TIME_SEC 5
// ----------------------------------------
// control word layout and reset value
// ----------------------------------------
`define MSCH_CTRL_MANUAL_BIT 0
`define MSCH_CTRL_START_BIT 1
`define MSCH_CTRL_RST 8'h00
// ----------------------------------------
// error numbers sent in error replies
// ----------------------------------------
`define MSCH_ERR_UNKNOWN 8'h01
`define MSCH_ERR_RANGE 8'h02
`define MSCH_ERR_CHAN_OFF 8'h03
`define MSCH_ERR_BELOW 8'h04
`define MSCH_ERR_ABOVE 8'h05
`endif

// ===== shared/msch_pkg.sv
package msch_pkg;
   // ----------------------------------------
   // decoded command codes
   // ----------------------------------------
   typedef enum logic [3:0]
   {
      MSCH_CMD_RESTORE = 4'b0000,
      MSCH_CMD_STORE = 4'b0001,
      MSCH_CMD_CAL_NOW = 4'b0010,
      MSCH_CMD_CTRL_WR = 4'b0011,
      MSCH_CMD_CTRL_RD = 4'b0100,
      MSCH_CMD_RESET = 4'b0101,
      MSCH_CMD_CFG_WR = 4'b0110,
      MSCH_CMD_MEAS_RD = 4'b0111
   } msch_cmd_t;

   // ----------------------------------------
   // reply kinds
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      MSCH_RPL_BANNER = 3'b000,
      MSCH_RPL_OK = 3'b001,
      MSCH_RPL_CTRL = 3'b010,
      MSCH_RPL_ERR = 3'b011,
      MSCH_RPL_VALUE = 3'b100
   } msch_rpl_t;

   typedef struct packed
   {
      msch_rpl_t kind;
      logic [7:0] data;
   } msch_reply_t;

   typedef struct packed
   {
      logic reply_valid;
      msch_reply_t reply;
      logic [7:0] ctrl;
      logic banner_pend;
      logic factory;
      logic store;
      logic cal_start;
      logic sched_restart;
   } msch_state_t;

   typedef struct packed
   {
      logic [25:0] pre;
      logic [11:0] sec;
      logic [2:0] fast_cnt;
      logic due;
   } msch_sched_t;
endpackage

// ===== verif/msch_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// host side of the serial link
// ----------------------------------------
module msch_host_model
(
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic slow_in,
   input wire logic reply_valid_in,
   input wire msch_pkg::msch_reply_t reply_in,
   output logic reply_ready_out,
   output int rx_cnt_out,
   output msch_pkg::msch_reply_t rx_last_out
);
   int wait_c;
   // ready raised after the edge, held until the accepting edge
   always @(negedge clk_in)
   begin
      if (!rst_b_in || reply_ready_out)
      begin
         reply_ready_out <= 1'b0;
         wait_c <= 0;
      end
      else if (reply_valid_in && (!slow_in || wait_c >= 3))
         reply_ready_out <= 1'b1;
      else if (reply_valid_in)
         wait_c <= wait_c + 1; // slow host stalls a few cycles
   end
   // a reply is taken whole at the handshake edge; values read while a
   // calibration runs would be discarded by a real host
   always @(posedge clk_in)
   begin
      if (reply_valid_in && reply_ready_out)
      begin
         rx_last_out <= reply_in;
         rx_cnt_out <= rx_cnt_out + 1;
      end
   end
   initial
   begin
      reply_ready_out = 1'b0;
      wait_c = 0;
      rx_cnt_out = 0;
      rx_last_out = '0;
   end
endmodule // msch_host_model

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`include "msch_params.svh"
module tb_top;
   localparam logic [7:0] FW_REL = 8'h2A; // arbitrary release code
   logic clk, rst_b, cmd_valid, param_ok, chan_on, meas_low, meas_high, reply_ready, host_slow;
   logic [3:0] cmd_code;
   logic [7:0] cmd_arg, ctrl_word;
   logic cmd_ready, reply_valid, factory, store, cal;
   msch_pkg::msch_reply_t reply, rx_last;
   int rx_cnt, n_mismatch, n_tests, n_cal, n_fac, n_sto, cyc;
   int cal_q[$];
   // short timer: 4 cycles a second, 12-cycle fast and 48-cycle slow period
   msch_top #(.CYC_PER_SEC(4), .FAST_SEC(3), .SLOW_SEC(12), .FW_RELEASE(FW_REL)) i_msch_top
   (
      .CLK_IN(clk), .RST_B_IN(rst_b), .CMD_VALID_IN(cmd_valid), .CMD_CODE_IN(cmd_code),
      .CMD_ARG_IN(cmd_arg), .PARAM_OK_IN(param_ok), .CHAN_ON_IN(chan_on), .MEAS_LOW_IN(meas_low),
      .MEAS_HIGH_IN(meas_high), .REPLY_READY_IN(reply_ready), .CMD_READY_OUT(cmd_ready),
      .REPLY_VALID_OUT(reply_valid), .REPLY_OUT(reply), .CTRL_WORD_OUT(ctrl_word),
      .FACTORY_LOAD_OUT(factory), .STORE_CFG_OUT(store), .CAL_START_OUT(cal)
   );
   msch_host_model i_msch_host_model
   (
      .clk_in(clk), .rst_b_in(rst_b), .slow_in(host_slow), .reply_valid_in(reply_valid),
      .reply_in(reply), .reply_ready_out(reply_ready), .rx_cnt_out(rx_cnt), .rx_last_out(rx_last)
   );
   // ----------------------------------------
   // clock, pulse counting and watchdog
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cal === 1'b1)
      begin
         n_cal <= n_cal + 1;
         cal_q.push_back(cyc);
      end
      if (factory === 1'b1)
         n_fac <= n_fac + 1;
      if (store === 1'b1)
         n_sto <= n_sto + 1;
      if (cyc > 6000)
      begin
         n_mismatch++; // hang cut short
         close_out();
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] rp(input msch_pkg::msch_rpl_t k, input logic [7:0] d);
      return {5'h00, k, d};
   endfunction
   // command held from a ready cycle until taken, then wait for the reply
   task automatic send(input logic [3:0] code, input logic [7:0] arg);
      int n;
      int r0;
      n = 0;
      r0 = rx_cnt;
      @(negedge clk);
      while (cmd_ready !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 200)
         n_mismatch++; // command never accepted
      cmd_code = code;
      cmd_arg = arg;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rx_cnt == r0 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      if (n >= 200)
         n_mismatch++; // reply never came
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_banner();
      check({15'h0000, cmd_ready}, 16'h0000);
      repeat (20) @(negedge clk);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_BANNER, FW_REL));
      check({14'h0000, cmd_ready, reply_valid}, 16'h0002);
   endtask
   // hardware reset mid-run: control word cleared, banner sent again
   task automatic t_hw_reset();
      int r;
      send(4'h3, 8'h01);
      r = rx_cnt;
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      check({15'h0000, cmd_ready}, 16'h0000);
      rst_b = 1'b1;
      repeat (20) @(negedge clk);
      check(16'(rx_cnt - r), 16'h0001);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_BANNER, FW_REL));
      check({8'h00, ctrl_word}, 16'h0000);
   endtask
   // manual mode under a slow host: readback and no automatic starts
   task automatic t_ctrl();
      int c;
      host_slow = 1'b1;
      send(4'h3, 8'h01);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_CTRL, 8'h01));
      check({8'h00, ctrl_word}, 16'h0001);
      send(4'h4, 8'h00);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_CTRL, 8'h01));
      c = n_cal;
      repeat (80) @(negedge clk);
      check(16'(n_cal - c), 16'h0000);
      host_slow = 1'b0;
   endtask
   // start bit: only a rising edge starts, holding it high does not
   task automatic t_start();
      int c;
      c = n_cal;
      send(4'h3, 8'h03);
      check(16'(n_cal - c), 16'h0001);
      send(4'h3, 8'h03);
      check(16'(n_cal - c), 16'h0001);
      send(4'h3, 8'h01); // host clears the start bit again
      send(4'h3, 8'h03);
      check(16'(n_cal - c), 16'h0002);
   endtask
   task automatic t_actions();
      int c;
      int s;
      c = n_cal;
      s = n_sto;
      send(4'h2, 8'h00);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_OK, 8'h00));
      check(16'(n_cal - c), 16'h0001);
      send(4'h1, 8'h00);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_OK, 8'h00));
      check(16'(n_sto - s), 16'h0001);
   endtask
   // every undefined code is refused and changes nothing
   task automatic t_unknown();
      int p;
      p = n_cal + n_fac + n_sto;
      for (int k = 8; k < 16; k++)
      begin
         send(4'(k), 8'h5A);
         check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_UNKNOWN));
      end
      check(16'(n_cal + n_fac + n_sto - p), 16'h0000);
      check({8'h00, ctrl_word}, 16'h0003);
   endtask
   task automatic t_range();
      param_ok = 1'b0;
      send(4'h6, 8'h07);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_RANGE));
      param_ok = 1'b1;
      send(4'h6, 8'h07);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_OK, 8'h00));
   endtask
   // channel off outranks the limit flags; below and above are each driven alone
   task automatic t_meas();
      logic [2:0] flags[4] = '{3'b011, 3'b110, 3'b101, 3'b100};
      logic [15:0] exp[4];
      exp[0] = rp(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_CHAN_OFF);
      exp[1] = rp(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_BELOW);
      exp[2] = rp(msch_pkg::MSCH_RPL_ERR, `MSCH_ERR_ABOVE);
      exp[3] = rp(msch_pkg::MSCH_RPL_VALUE, 8'h02);
      for (int k = 0; k < 4; k++)
      begin
         {chan_on, meas_low, meas_high} = flags[k];
         send(4'h7, 8'h02);
         check({5'h00, rx_last}, exp[k]);
      end
   endtask
   task automatic t_restore();
      int f;
      f = n_fac;
      send(4'h0, 8'h00);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_BANNER, FW_REL));
      check(16'(n_fac - f), 16'h0001);
      check({8'h00, ctrl_word}, {8'h00, `MSCH_CTRL_RST});
      send(4'h3, 8'h01);
      send(4'h5, 8'h00);
      check({5'h00, rx_last}, rp(msch_pkg::MSCH_RPL_BANNER, FW_REL));
      check({8'h00, ctrl_word}, 16'h0000);
   endtask
   // timer restarted by the reset command: four fast periods, then slow
   task automatic t_auto();
      cal_q.delete();
      repeat (130) @(negedge clk);
      check(16'(cal_q.size() >= 5), 16'h0001);
      if (cal_q.size() >= 5)
      begin
         check(16'(cal_q[1] - cal_q[0]), 16'h000C);
         check(16'(cal_q[4] - cal_q[3]), 16'h0030);
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {rst_b, cmd_valid, param_ok, chan_on, meas_low, meas_high, host_slow} = 7'h00;
      cmd_code = 4'h0;
      cmd_arg = 8'h00;
      {n_mismatch, n_tests, n_cal, n_fac, n_sto, cyc} = {6{32'h0}};
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      t_banner();
      t_ctrl();
      t_start();
      t_actions();
      t_unknown();
      t_range();
      t_meas();
      t_restore();
      t_auto();
      t_hw_reset();
      close_out();
   end
endmodule // tb_top
